// file: verilog/rlgl_pkg.sv
// package: register map, field layout, reset values and timing of the record gain loop
package rlgl_pkg;
    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_LIMITS = 8'h20;
    localparam logic [7:0] IDX_HOLD_TGT = 8'h21;
    localparam logic [7:0] IDX_MODE_RATE = 8'h22;
    localparam logic [7:0] IDX_NGATE = 8'h23;
    localparam logic [7:0] IDX_STATUS = 8'h24;

    // field positions
    localparam int EN_BIT = 8;
    localparam int CEIL_LSB = 3;
    localparam int FLOOR_LSB = 0;
    localparam int ZC_BIT = 8;
    localparam int HOLD_LSB = 4;
    localparam int TGT_LSB = 0;
    localparam int MODE_BIT = 8;
    localparam int UP_LSB = 4;
    localparam int DN_LSB = 0;
    localparam int NGEN_BIT = 3;
    localparam int NOISE_THRESHOLD_SEL_LSB = 0;
    localparam int ST_GATE_BIT = 6;
    localparam int ST_CLIP_BIT = 7;

    // reset values of the fields that are not zero
    localparam logic [2:0] CEIL_RST = 3'h7;
    localparam logic [3:0] TGT_RST = 4'hb;
    localparam logic [3:0] UP_RST = 4'h3;
    localparam logic [3:0] DN_RST = 4'h2;
    localparam logic [5:0] GAIN_RST = 6'h10;

    // gain codes step 0.75 dB from -12 dB at code 0
    localparam logic [5:0] CEIL_BASE = 6'h07;
    // levels in 1/8 octave units, full scale at 128
    localparam logic [6:0] TGT_LVL_BASE = 7'h5a;
    localparam logic [7:0] NG_BASE = 8'h3c;
    localparam logic [14:0] CLIP_MAG = 15'h7000;
    localparam logic [3:0] RATE_CAP = 4'ha;
    localparam logic [3:0] HOLD_CAP = 4'he;
    localparam int CNT_W = 26;

    // timing: clock, loop tick and per-step times in ns
    localparam int CLK_NS = 10;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int HOLD_NS = 2670000;
    localparam int UP_LVL_NS = 410000;
    localparam int DN_LVL_NS = 104000;
    localparam int UP_LIM_NS = 90800;
    localparam int DN_LIM_NS = 22700;
    // least times, rounded up to whole ticks
    localparam logic [11:0] HOLD_TK = 12'((HOLD_NS + TICK_NS - 1) / TICK_NS);
    localparam logic [11:0] UP_LVL_TK = 12'((UP_LVL_NS + TICK_NS - 1) / TICK_NS);
    localparam logic [11:0] DN_LVL_TK = 12'((DN_LVL_NS + TICK_NS - 1) / TICK_NS);
    localparam logic [11:0] UP_LIM_TK = 12'((UP_LIM_NS + TICK_NS - 1) / TICK_NS);
    localparam logic [11:0] DN_LIM_TK = 12'((DN_LIM_NS + TICK_NS - 1) / TICK_NS);
endpackage

// file: verilog/rlgl_level_meter.sv
// level meter: peak magnitude, log level, clip flag and zero-cross pulse
`timescale 1ns/100ps
module rlgl_level_meter (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic sample_valid,
    input wire logic [15:0] sample_data,
    input wire logic clear,
    output logic [6:0] level,
    output logic clip,
    output logic zero_cross
);
    typedef struct packed {
        logic [14:0] peak;
        logic [6:0] lvl;
        logic clip;
        logic sign;
        logic zc;
    } rlgl_meter_s;

    rlgl_meter_s s_r;
    rlgl_meter_s s_nxt;
    logic [14:0] mag;
    logic [14:0] base;

    // log2 in eighths of an octave: leading one plus three bits below it
    function automatic logic [6:0] rlgl_log(input logic [14:0] m);
        logic [6:0] r;
        logic [14:0] t;
        r = 7'h00;
        t = 15'h0000;
        for (int p = 0; p < 15; p++) begin
            if (m[p]) begin
                t = m << (14 - p);
                r = 7'((p + 1) * 8) + {4'h0, t[13:11]};
            end
        end
        return r;
    endfunction

    // -32768 has no positive twin, so it saturates
    always_comb begin
        if (sample_data[15]) begin
            mag = (sample_data == 16'h8000) ? 15'h7fff : 15'(-sample_data);
        end else begin
            mag = sample_data[14:0];
        end
    end

    // a clear in the same cycle as a sample keeps that sample
    assign base = clear ? 15'h0000 : s_r.peak;

    always_comb begin
        s_nxt = s_r;
        s_nxt.zc = 1'b0;
        if (clear) begin
            s_nxt.clip = 1'b0;
        end
        s_nxt.peak = base;
        if (sample_valid) begin
            if (mag > base) begin
                s_nxt.peak = mag;
            end
            if (mag > rlgl_pkg::CLIP_MAG) begin
                s_nxt.clip = 1'b1; // [RULE6]
            end
            // a sign change or an exact zero counts as a crossing
            s_nxt.zc = (sample_data[15] != s_r.sign) || (sample_data == 16'h0000);
            s_nxt.sign = sample_data[15];
        end
        s_nxt.lvl = rlgl_log(s_nxt.peak);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level = s_r.lvl;
    assign clip = s_r.clip;
    assign zero_cross = s_r.zc;
endmodule

// file: verilog/rlgl_gain_loop.sv
// record gain loop: register slave, level/limiter control, clip guard and noise gate
//
// Behaviour
// [RULE1] ceiling field picks top gain, 6dB steps, -6.75dB to +35.25dB, resets 111
// [RULE2] floor field picks lowest gain, 6dB steps, -12dB to +30dB, resets 000
// [RULE3] hold delays ramp-up; zero at 0000, 2.67ms at 0001, doubling per code
// [RULE4] target sets ADC level, -28.5dB to -6dB in 1.5dB steps, resets 1011
// [RULE5] zero-cross bit set applies gain changes only at zero crossings; resets 0
// [RULE6] input above 87.5% full scale ramps gain down at fastest attack rate
// [RULE7] clip guard always on while loop enabled; no effect at attack code 0000
// [RULE8] gate engages when ADC level below threshold plus gain plus boost
// [RULE9] while gated the gain is held and never ramps up; the code still steps it down when the level is over target
// [RULE10] gate threshold -39dB at 000 to -81dB at 111, 6dB per code, resets 000
// [RULE11] gate acts only with its enable and the loop enabled; enable resets 0
// [RULE12] loop enable resets 0; setting 1 runs the selected mode
// [RULE13] mode 1 limits peaks, never above static gain; mode 0 regulates to target
// [RULE14] level-mode ramp-up 3.3ms per 6dB at 0000, doubling, capped at 1010
// [RULE15] level-mode ramp-down 832us per 6dB at 0000, doubling, capped at 1010
// [RULE16] limiter mode runs about four times faster and skips the hold delay
`timescale 1ns/100ps
module rlgl_gain_loop #(
    parameter logic [11:0] TICK_CYC = 12'(rlgl_pkg::TICK_CYC)
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic adc_valid,
    input wire logic [15:0] adc_data,
    input wire logic [5:0] static_gain,
    input wire logic [5:0] mic_boost,
    output logic [5:0] pga_gain,
    output logic gate_active,
    output logic clip_active
);
    typedef struct packed {
        logic ack;
        logic [8:0] rdata;
        logic en;
        logic [2:0] ceil;
        logic [2:0] floor;
        logic zc_en;
        logic [3:0] hold;
        logic [3:0] target;
        logic mode;
        logic [3:0] up;
        logic [3:0] dn;
        logic ng_en;
        logic [2:0] noise_threshold_sel;
        logic [11:0] pre;
        logic tick;
        logic [rlgl_pkg::CNT_W-1:0] atk_cnt;
        logic [rlgl_pkg::CNT_W-1:0] dcy_cnt;
        logic [rlgl_pkg::CNT_W-1:0] hold_cnt;
        logic hold_done;
        logic [5:0] gain;
        logic [5:0] pga;
        logic peak_clr;
        logic gate;
    } rlgl_state_s;

    localparam rlgl_state_s ST_RST = '{
        ceil: rlgl_pkg::CEIL_RST,
        target: rlgl_pkg::TGT_RST,
        up: rlgl_pkg::UP_RST,
        dn: rlgl_pkg::DN_RST,
        gain: rlgl_pkg::GAIN_RST,
        pga: rlgl_pkg::GAIN_RST,
        default: '0
    };

    rlgl_state_s s_r;
    rlgl_state_s s_nxt;

    logic [6:0] level;
    logic clip;
    logic zero_cross;
    logic req;
    logic [6:0] target_lvl;
    logic over;
    logic [7:0] gate_thr;
    logic gate;
    logic [5:0] ceil_g;
    logic [5:0] ceil_eff;
    logic [5:0] floor_g;
    logic [rlgl_pkg::CNT_W-1:0] atk_len;
    logic [rlgl_pkg::CNT_W-1:0] dcy_len;
    logic [rlgl_pkg::CNT_W-1:0] hold_len;
    logic [rlgl_pkg::CNT_W-1:0] atk_inc;
    logic [rlgl_pkg::CNT_W-1:0] dcy_inc;
    logic [rlgl_pkg::CNT_W-1:0] hold_inc;

    // one step length: base ticks doubled per code, code capped
    function automatic logic [rlgl_pkg::CNT_W-1:0] rlgl_len(
        input logic [11:0] base,
        input logic [3:0] code,
        input logic [3:0] cap
    );
        logic [3:0] c;
        c = (code > cap) ? cap : code;
        return rlgl_pkg::CNT_W'(base) << c;
    endfunction

    // byte-address decode of one register index
    function automatic logic rlgl_hit(input logic [7:0] addr, input logic [7:0] idx);
        return addr == {idx[5:0], 2'b00};
    endfunction

    rlgl_level_meter u_meter (
        .core_clk(core_clk),
        .nrst(nrst),
        .sample_valid(adc_valid),
        .sample_data(adc_data),
        .clear(s_r.peak_clr),
        .level(level),
        .clip(clip),
        .zero_cross(zero_cross)
    );

    // bus request seen; waitrequest drops one cycle later
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~s_r.ack;
    assign avs_readdata = {23'h00_0000, s_r.rdata};

    // target in eighth-octave units: 2 units per 1.5 dB code
    assign target_lvl = rlgl_pkg::TGT_LVL_BASE + {2'b00, s_r.target, 1'b0}; // [RULE4]
    // clip forces the attack branch even below target
    assign over = (level > target_lvl) | clip; // [RULE6] [RULE7]

    // gate threshold at the ADC: threshold plus gain plus boost
    assign gate_thr = rlgl_pkg::NG_BASE - {2'b00, s_r.noise_threshold_sel, 3'b000}
                    + {2'b00, s_r.gain} + {2'b00, mic_boost}; // [RULE8] [RULE10]
    assign gate = s_r.en & s_r.ng_en & ({1'b0, level} < gate_thr); // [RULE11]

    // gain limits in 0.75 dB codes
    assign ceil_g = rlgl_pkg::CEIL_BASE + {s_r.ceil, 3'b000}; // [RULE1]
    assign floor_g = {s_r.floor, 3'b000}; // [RULE2]
    // the limiter may only restore, never exceed the static gain
    assign ceil_eff = (s_r.mode && static_gain < ceil_g) ? static_gain : ceil_g; // [RULE13]

    // step lengths; limiter uses its own faster bases
    always_comb begin
        if (s_r.mode) begin
            dcy_len = rlgl_len(rlgl_pkg::UP_LIM_TK, s_r.up, rlgl_pkg::RATE_CAP); // [RULE16]
            atk_len = rlgl_len(rlgl_pkg::DN_LIM_TK, clip ? 4'h0 : s_r.dn, rlgl_pkg::RATE_CAP);
        end else begin
            dcy_len = rlgl_len(rlgl_pkg::UP_LVL_TK, s_r.up, rlgl_pkg::RATE_CAP); // [RULE14]
            atk_len = rlgl_len(rlgl_pkg::DN_LVL_TK, clip ? 4'h0 : s_r.dn,
                               rlgl_pkg::RATE_CAP); // [RULE15] [RULE6]
        end
        if (s_r.hold == 4'h0) begin
            hold_len = '0;
        end else begin
            hold_len = rlgl_len(rlgl_pkg::HOLD_TK, s_r.hold - 4'h1, rlgl_pkg::HOLD_CAP); // [RULE3]
        end
    end

    assign atk_inc = s_r.atk_cnt + 26'h000_0001;
    assign dcy_inc = s_r.dcy_cnt + 26'h000_0001;
    assign hold_inc = s_r.hold_cnt + 26'h000_0001;

    // all next-state logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        s_nxt.peak_clr = 1'b0;

        // loop tick divider
        if (s_r.pre >= TICK_CYC - 12'h001) begin
            s_nxt.pre = 12'h000;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.pre = s_r.pre + 12'h001;
        end

        // avalon slave: read data captured while waitrequest is high
        s_nxt.ack = req & ~s_r.ack;
        if (avs_read && !s_r.ack) begin
            s_nxt.rdata = 9'h000;
            if (rlgl_hit(avs_address, rlgl_pkg::IDX_LIMITS)) begin
                s_nxt.rdata[rlgl_pkg::EN_BIT] = s_r.en;
                s_nxt.rdata[rlgl_pkg::CEIL_LSB +: 3] = s_r.ceil;
                s_nxt.rdata[rlgl_pkg::FLOOR_LSB +: 3] = s_r.floor;
            end else if (rlgl_hit(avs_address, rlgl_pkg::IDX_HOLD_TGT)) begin
                s_nxt.rdata[rlgl_pkg::ZC_BIT] = s_r.zc_en;
                s_nxt.rdata[rlgl_pkg::HOLD_LSB +: 4] = s_r.hold;
                s_nxt.rdata[rlgl_pkg::TGT_LSB +: 4] = s_r.target;
            end else if (rlgl_hit(avs_address, rlgl_pkg::IDX_MODE_RATE)) begin
                s_nxt.rdata[rlgl_pkg::MODE_BIT] = s_r.mode;
                s_nxt.rdata[rlgl_pkg::UP_LSB +: 4] = s_r.up;
                s_nxt.rdata[rlgl_pkg::DN_LSB +: 4] = s_r.dn;
            end else if (rlgl_hit(avs_address, rlgl_pkg::IDX_NGATE)) begin
                s_nxt.rdata[rlgl_pkg::NGEN_BIT] = s_r.ng_en;
                s_nxt.rdata[rlgl_pkg::NOISE_THRESHOLD_SEL_LSB +: 3] = s_r.noise_threshold_sel;
            end else if (rlgl_hit(avs_address, rlgl_pkg::IDX_STATUS)) begin
                s_nxt.rdata[5:0] = s_r.pga;
                s_nxt.rdata[rlgl_pkg::ST_GATE_BIT] = s_r.gate;
                s_nxt.rdata[rlgl_pkg::ST_CLIP_BIT] = clip;
            end
        end

        // writes land at the edge where waitrequest is low; bit 8 rides lane 1
        if (avs_write && s_r.ack) begin
            if (rlgl_hit(avs_address, rlgl_pkg::IDX_LIMITS)) begin
                if (avs_byteenable[1]) begin
                    s_nxt.en = avs_writedata[rlgl_pkg::EN_BIT]; // [RULE12]
                end
                if (avs_byteenable[0]) begin
                    s_nxt.ceil = avs_writedata[rlgl_pkg::CEIL_LSB +: 3];
                    s_nxt.floor = avs_writedata[rlgl_pkg::FLOOR_LSB +: 3];
                end
            end else if (rlgl_hit(avs_address, rlgl_pkg::IDX_HOLD_TGT)) begin
                if (avs_byteenable[1]) begin
                    s_nxt.zc_en = avs_writedata[rlgl_pkg::ZC_BIT];
                end
                if (avs_byteenable[0]) begin
                    s_nxt.hold = avs_writedata[rlgl_pkg::HOLD_LSB +: 4];
                    s_nxt.target = avs_writedata[rlgl_pkg::TGT_LSB +: 4];
                end
            end else if (rlgl_hit(avs_address, rlgl_pkg::IDX_MODE_RATE)) begin
                if (avs_byteenable[1]) begin
                    s_nxt.mode = avs_writedata[rlgl_pkg::MODE_BIT];
                end
                if (avs_byteenable[0]) begin
                    s_nxt.up = avs_writedata[rlgl_pkg::UP_LSB +: 4];
                    s_nxt.dn = avs_writedata[rlgl_pkg::DN_LSB +: 4];
                end
            end else if (rlgl_hit(avs_address, rlgl_pkg::IDX_NGATE)) begin
                if (avs_byteenable[0]) begin
                    s_nxt.ng_en = avs_writedata[rlgl_pkg::NGEN_BIT];
                    s_nxt.noise_threshold_sel = avs_writedata[rlgl_pkg::NOISE_THRESHOLD_SEL_LSB +: 3];
                end
            end
        end

        s_nxt.gate = gate; // [RULE11]

        // gain loop: disabled tracks the static gain so enabling starts from it
        if (!s_r.en) begin
            s_nxt.gain = static_gain; // [RULE12]
            s_nxt.atk_cnt = '0;
            s_nxt.dcy_cnt = '0;
            s_nxt.hold_cnt = '0;
            s_nxt.hold_done = 1'b0;
        end else if (s_r.tick) begin
            if (over) begin
                // no hold before ramping down; any loud peak restarts the hold
                s_nxt.dcy_cnt = '0;
                s_nxt.hold_cnt = '0;
                s_nxt.hold_done = 1'b0;
                if (atk_inc >= atk_len) begin
                    s_nxt.atk_cnt = '0;
                    s_nxt.peak_clr = 1'b1;
                    if (s_r.gain > floor_g) begin
                        s_nxt.gain = s_r.gain - 6'h01; // [RULE2] [RULE6]
                    end
                end else begin
                    s_nxt.atk_cnt = atk_inc;
                end
            end else begin
                s_nxt.atk_cnt = '0;
                if (!s_r.hold_done && !s_r.mode && hold_len != '0) begin
                    // hold runs only in level mode
                    if (hold_inc >= hold_len) begin
                        s_nxt.hold_done = 1'b1; // [RULE3] [RULE16]
                        s_nxt.hold_cnt = '0;
                    end else begin
                        s_nxt.hold_cnt = hold_inc;
                    end
                end else if (dcy_inc >= dcy_len) begin
                    s_nxt.dcy_cnt = '0;
                    s_nxt.peak_clr = 1'b1;
                    // a closed gate blocks the up step instead of pumping noise
                    if (!gate && s_r.gain < ceil_eff) begin
                        s_nxt.gain = s_r.gain + 6'h01; // [RULE9] [RULE1] [RULE13]
                    end
                end else begin
                    s_nxt.dcy_cnt = dcy_inc;
                end
            end
        end

        // amplifier update, deferred to a crossing when asked; no timeout,
        // so a dc input keeps the old gain until it crosses
        if (!s_r.en) begin
            s_nxt.pga = static_gain;
        end else if (!s_r.zc_en || zero_cross) begin
            s_nxt.pga = s_r.gain; // [RULE5]
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pga_gain = s_r.pga;
    assign gate_active = s_r.gate;
    assign clip_active = clip;
endmodule

// file: tb/rlgl_monitor.sv
// checker: bus handshake, read data, clip flag and gate hold of the record gain loop
`timescale 1ns/100ps
module rlgl_monitor #(
    parameter logic [11:0] TICK_CYC = 12'h064
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic adc_valid,
    input wire logic [15:0] adc_data,
    input wire logic [5:0] static_gain,
    input wire logic [5:0] mic_boost,
    input wire logic [5:0] pga_gain,
    input wire logic gate_active,
    input wire logic clip_active
);
    logic [15:0] mag;
    // sample magnitude; the most negative code still counts as loud
    assign mag = adc_data[15] ? 16'(-adc_data) : adc_data;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_req;
        avs_read || avs_write;
    endsequence
    sequence s_waiting;
        s_req ##0 avs_waitrequest;
    endsequence
    sequence s_acked;
        s_req ##0 !avs_waitrequest;
    endsequence
    a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("new request not held off");
    a_wait_one: assert property (s_waiting |=> !avs_waitrequest || !(avs_read || avs_write))
        else $error("more than one wait cycle");
    a_wait_again: assert property (s_acked |=> avs_waitrequest || !(avs_read || avs_write))
        else $error("held request answered twice");
    a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without request");
    a_rd_upper: assert property (s_acked ##0 avs_read |-> avs_readdata[31:9] == 23'h0)
        else $error("unused read bits not zero");
    a_rd_stable: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without read");
    a_clip_flag: assert property (adc_valid && mag > 16'h7000 |=> clip_active)
        else $error("loud sample not flagged");
    a_gate_hold: assert property (gate_active [*2] |-> pga_gain <= $past(pga_gain))
        else $error("gain rose while gated");
endmodule
bind rlgl_gain_loop rlgl_monitor #(.TICK_CYC(TICK_CYC)) mon_u (.core_clk(core_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .adc_valid(adc_valid), .adc_data(adc_data),
    .static_gain(static_gain), .mic_boost(mic_boost), .pga_gain(pga_gain),
    .gate_active(gate_active), .clip_active(clip_active));

// file: tb/rlgl_amp_adc.sv
// partner model: input amplifier and ADC sample stream feeding the gain loop
`timescale 1ns/100ps
module rlgl_amp_adc (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [15:0] in_amp,
    input wire logic dc_in,
    input wire logic [5:0] pga_gain,
    output logic adc_valid,
    output logic [15:0] adc_data
);
    logic [1:0] div_r;
    logic neg_r;
    logic [31:0] mag;
    logic [15:0] smp;
    // amplifier doubles per eight gain codes; the converter saturates at full scale
    assign mag = 32'(in_amp) << pga_gain[5:3];
    assign smp = (mag > 32'h0000_7fff) ? 16'h7fff : mag[15:0];
    // one sample every fourth clock, alternating sign so each sample crosses zero;
    // dc_in keeps every sample positive so no crossing is ever seen
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= 2'h0;
            neg_r <= 1'b0;
            adc_valid <= 1'b0;
            adc_data <= 16'h0000;
        end else begin
            div_r <= div_r + 2'h1;
            adc_valid <= (div_r == 2'h3);
            if (div_r == 2'h3) begin
                neg_r <= !neg_r;
                adc_data <= (neg_r && !dc_in) ? 16'(-smp) : smp;
            end else begin
                adc_data <= ~adc_data; // data is not held outside the strobe
            end
        end
    end
endmodule

// file: tb/rlgl_gain_loop_tb.sv
// testbench: registers, level control, clip guard, noise gate and limiter of the gain loop
`timescale 1ns/100ps
module rlgl_gain_loop_tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, adc_valid, gate_active, clip_active;
    logic [15:0] adc_data;
    logic [15:0] in_amp = 16'h0010;
    logic dc_in = 1'b0;
    logic [5:0] static_gain = 6'h14;
    logic [5:0] mic_boost = 6'h00;
    logic [5:0] pga_gain;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int errors = 0;
    int checks_done = 0;
    integer seed = 32'hdb49f27b;

    always #5 core_clk = ~core_clk;

    // short loop tick keeps every ramp count small
    rlgl_gain_loop #(.TICK_CYC(12'h002)) dut_u (.core_clk(core_clk), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .adc_valid(adc_valid), .adc_data(adc_data), .static_gain(static_gain),
        .mic_boost(mic_boost), .pga_gain(pga_gain), .gate_active(gate_active),
        .clip_active(clip_active));
    rlgl_amp_adc amp_u (.core_clk(core_clk), .nrst(nrst), .in_amp(in_amp), .dc_in(dc_in),
        .pga_gain(pga_gain), .adc_valid(adc_valid), .adc_data(adc_data));

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask

    // one bus access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // note the expected word, then read; the watcher compares
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // loop held off while the other fields change, enabled by the last write
    task automatic cfg(input logic [31:0] lim, ht, mr, ng);
        bus(1'b1, 8'h80, lim & 32'h0000_00ff);
        bus(1'b1, 8'h84, ht);
        bus(1'b1, 8'h88, mr);
        bus(1'b1, 8'h8c, ng);
        bus(1'b1, 8'h80, lim);
    endtask

    task automatic pause(input int n, input string s);
        repeat (n) @(posedge core_clk);
        $display("test %0s done", s);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watcher: each completed read takes the oldest note
    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) chk(avs_readdata, 32'hdead_beef);
            else chk(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
        end
    end

    // hang guard, well beyond the sum of all waits
    initial begin
        repeat (80000) @(posedge core_clk);
        errors++;
        test_done();
    end

    initial begin
        int i;
        logic [31:0] v;
        logic [7:0] a;
        logic [31:0] m;
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        rd(8'h80, 32'h0000_0038, 32'hffff_ffff);
        rd(8'h84, 32'h0000_000b, 32'hffff_ffff);
        rd(8'h88, 32'h0000_0032, 32'hffff_ffff);
        rd(8'h8c, 32'h0000_0000, 32'hffff_ffff);
        rd(8'ha0, 32'h0000_0000, 32'hffff_ffff);
        rd(8'h90, 32'h0000_0014, 32'h0000_007f);
        pause(1, "reset");
        // random field values written and read back, back to back
        for (i = 0; i < 8; i++) begin
            v = 32'($random(seed)) & 32'h0000_01ff;
            a = 8'h80 + 8'(4 * (i % 4));
            bus(1'b1, a, v);
            // limits keeps no bits 7:6, the gate register only bits 3:0
            m = (i % 4 == 3) ? 32'h0000_000f : ((i % 4 == 0) ? 32'h0000_013f : 32'h0000_01ff);
            rd(a, v & m, 32'hffff_ffff);
        end
        pause(1, "fields");
        // level mode, floor 16, ceiling 31, loud input ramps to the floor
        in_amp <= 16'h7fff;
        cfg(32'h0000_011a, 32'h0000_000b, 32'h0000_0000, 32'h0000_0000);
        pause(3000, "clip");
        rd(8'h90, 32'h0000_0010, 32'h0000_003f);
        // quiet input with the gate on: gain frozen at the floor
        in_amp <= 16'h0010;
        bus(1'b1, 8'h8c, 32'h0000_0008);
        pause(3000, "gate");
        rd(8'h90, 32'h0000_0050, 32'h0000_007f);
        // gate off: gain climbs to the ceiling code and stops
        bus(1'b1, 8'h8c, 32'h0000_0000);
        pause(14000, "ceiling");
        rd(8'h90, 32'h0000_001f, 32'h0000_007f);
        // gate enabled but loop off: no gating, gain follows static gain
        bus(1'b1, 8'h8c, 32'h0000_0008);
        bus(1'b1, 8'h80, 32'h0000_001a);
        rd(8'h90, 32'h0000_0014, 32'h0000_007f);
        // limiter: quiet input never lifts gain above static
        cfg(32'h0000_011a, 32'h0000_000b, 32'h0000_0100, 32'h0000_0000);
        pause(2000, "limiter quiet");
        rd(8'h90, 32'h0000_0014, 32'h0000_003f);
        // limiter attack is fast enough that level mode could not reach the floor
        in_amp <= 16'h7fff;
        pause(600, "limiter loud");
        rd(8'h90, 32'h0000_0010, 32'h0000_003f);
        // zero-cross apply with a dc input: the amplifier keeps static gain until a crossing
        dc_in <= 1'b1;
        cfg(32'h0000_011a, 32'h0000_010b, 32'h0000_0000, 32'h0000_0000);
        pause(1500, "zero cross hold");
        rd(8'h90, 32'h0000_0014, 32'h0000_003f);
        dc_in <= 1'b0;
        pause(100, "zero cross apply");
        rd(8'h90, 32'h0000_0010, 32'h0000_003f);
        test_done();
    end
endmodule
